// [verilog/reset_config_sampler_regs.vh]
`ifndef RESET_CONFIG_SAMPLER_REGS_VH
`define RESET_CONFIG_SAMPLER_REGS_VH

// power-on reset output hold, in clocks
`define POR_HOLD_CLOCKS        16'd512
// watchdog timeout figure and its cycle count at 200 MHz (5 ns period)
`define WDOG_TIMEOUT_MS        16
`define CLK_PERIOD_PS          5000
`define WDOG_TIMEOUT_CYCLES    ((`WDOG_TIMEOUT_MS * 64'd1000000000) / `CLK_PERIOD_PS)
// watchdog service sequence
`define WDOG_KEY_FIRST         8'h55
`define WDOG_KEY_SECOND        8'hAA
// boot chip-select strobe counts per port width
`define BOOT_PULSES_WIDE       4'd5
`define BOOT_PULSES_NARROW     4'd9
// reset vector fetch address increment per access
`define BOOT_INCR_WIDE         3'd2
`define BOOT_INCR_NARROW       3'd1
// system clock to crystal ratio with the loop running
`define PLL_MULTIPLIER         10'd512
// system protection control: watchdog enable bit position and reset value
`define SYSPROT_WDE_BIT        7
`define SYSPROT_RESET          8'h80

`endif

// [verilog/boot_strobe_gen.v]
`timescale 1ns/10ps
`default_nettype none

// counts out the boot chip-select strobes after reset
module boot_strobe_gen (
	// clock and reset
	input  wire       mclk_i,
	input  wire       srst_i,
	// control
	input  wire       start_i,
	input  wire [3:0] count_i,
	// strobe
	output reg        boot_cs_n_o,
	output reg        done_o
);

	reg [3:0] left_q;
	reg       phase_q;

	always @(posedge mclk_i) begin
		if (srst_i) begin
			left_q      <= 4'h0;
			phase_q     <= 1'b0;
			boot_cs_n_o <= 1'b1;
			done_o      <= 1'b0;
		end else if (start_i) begin
			left_q      <= count_i;
			phase_q     <= 1'b0;
			boot_cs_n_o <= 1'b1;
			done_o      <= 1'b0;
		end else if (left_q != 4'h0) begin
			// one clock low, one clock high per strobe
			phase_q     <= ~phase_q;
			boot_cs_n_o <= phase_q;
			if (phase_q) begin
				left_q <= left_q - 4'h1;
				if (left_q == 4'h1)
					done_o <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// [verilog/reset_config_sampler.v]
// Contract
// - mode pin high selects loop, low bypass
// - boot width bit sets port and increment
// - interrupt bit low makes pins port
// - arbitration bit high gives pins chip-select
// - level 7 held until vectors fetched
// - watchdog on after reset, timeout resets
// - clearing enable bit stops watchdog
// - protection control writable once per reset
// - breakpoint low at release enables debug
// - bus request or grant ack releases bus (the code releases only while the arbitration bit is low)
// - boot strobe five or nine pulses
// - reset output low at least 512 clocks
// - loop mode clock is 512 times crystal
`timescale 1ns/10ps
`default_nettype none
`include "reset_config_sampler_regs.vh"

module reset_config_sampler #(
	parameter [63:0] WDOG_CYCLES = `WDOG_TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire        mclk_i,
	input  wire        srst_i,
	// pll status
	input  wire        pll_locked_i,
	// reset configuration straps (asynchronous pins)
	input  wire        clock_mode_select_pin_i,
	input  wire        boot_width_config_bit_i,
	input  wire        arbitration_pin_config_bit_i,
	input  wire        interrupt_pin_config_bit_i,
	input  wire        breakpoint_request_pin_n_i,
	// bus arbitration and interrupt pins (asynchronous)
	input  wire        bus_request_pin_n_i,
	input  wire        bus_grant_ack_pin_n_i,
	input  wire        level7_interrupt_request_n_i,
	// processor progress
	input  wire        vector_fetch_done_i,
	// system protection control write port
	input  wire        sysprot_wr_i,
	input  wire [7:0]  sysprot_wdata_i,
	// watchdog service write port
	input  wire        wdog_service_wr_i,
	input  wire [7:0]  wdog_service_data_i,
	// reset and clock configuration
	output reg         reset_out_n_o,
	output reg         pll_enable_o,
	output wire [9:0]  clock_multiplier_o,
	// boot configuration
	output reg         boot_port_wide_o,
	output wire [2:0]  boot_addr_incr_o,
	output wire        boot_chip_select_n_o,
	output wire        boot_strobes_done_o,
	// pin assignment
	output reg         interrupt_port_pins_o,
	output reg         arb_pins_chip_select_o,
	// processor control
	output reg         background_debug_mode_en_o,
	output reg         background_debug_mode_enter_o,
	output reg         level7_interrupt_o,
	output reg         bus_released_o,
	// watchdog
	output reg         watchdog_enable_o,
	output reg         sysprot_written_o,
	output reg         watchdog_reset_o
);

	// two-flop synchronisers for every pin
	localparam NPIN = 8;
	reg  [NPIN-1:0] sync1_q;
	reg  [NPIN-1:0] sync2_q;
	wire [NPIN-1:0] pins_raw = {level7_interrupt_request_n_i, bus_grant_ack_pin_n_i,
	                            bus_request_pin_n_i, breakpoint_request_pin_n_i,
	                            interrupt_pin_config_bit_i, arbitration_pin_config_bit_i,
	                            boot_width_config_bit_i, clock_mode_select_pin_i};

	always @(posedge mclk_i) begin
		sync1_q <= pins_raw;
		sync2_q <= sync1_q;
	end

	wire s_clk_mode     = sync2_q[0];
	wire s_width        = sync2_q[1];
	wire s_arb          = sync2_q[2];
	wire s_irqcfg       = sync2_q[3];
	wire s_break_n      = sync2_q[4];
	wire s_busreq_n     = sync2_q[5];
	wire s_grant_ack_n  = sync2_q[6];
	wire s_level7_n     = sync2_q[7];

	// reset release sequencing
	localparam ST_HOLD = 2'd0;
	localparam ST_LOCK = 2'd1;
	localparam ST_RUN  = 2'd2;

	reg [1:0]  state_q;
	reg [15:0] por_cnt_q;
	reg [63:0] wdog_cnt_q;
	reg        wdog_expired_q;
	reg        wdog_key_armed_q;
	reg        strobe_start_q;
	reg        brk_prev_q;

	localparam [7:0] SYSPROT_INIT = `SYSPROT_RESET;

	always @(posedge mclk_i) begin
		if (srst_i || wdog_expired_q) begin
			state_q        <= ST_HOLD;
			por_cnt_q      <= 16'h0000;
			reset_out_n_o  <= 1'b0;
			strobe_start_q <= 1'b0;
		end else begin
			strobe_start_q <= 1'b0;
			case (state_q)
				ST_HOLD: begin
					if (por_cnt_q < `POR_HOLD_CLOCKS - 16'd1)
						por_cnt_q <= por_cnt_q + 16'd1;
					else if (s_clk_mode)
						state_q <= ST_LOCK; // loop must lock first
					else
						state_q <= ST_RUN;
					if (por_cnt_q >= `POR_HOLD_CLOCKS - 16'd1 && !s_clk_mode) begin
						reset_out_n_o  <= 1'b1;
						strobe_start_q <= 1'b1;
					end
				end
				ST_LOCK: begin
					if (pll_locked_i) begin
						state_q        <= ST_RUN;
						reset_out_n_o  <= 1'b1;
						strobe_start_q <= 1'b1;
					end
				end
				ST_RUN: begin
					reset_out_n_o <= 1'b1;
				end
				default: state_q <= ST_HOLD;
			endcase
		end
	end

	// straps: tracked while held, frozen at release until the next reset
	wire in_reset = srst_i || wdog_expired_q || state_q != ST_RUN;

	always @(posedge mclk_i) begin
		if (srst_i) begin
			pll_enable_o               <= 1'b0;
			boot_port_wide_o           <= 1'b0;
			interrupt_port_pins_o      <= 1'b0;
			arb_pins_chip_select_o     <= 1'b0;
			background_debug_mode_en_o <= 1'b0;
		end else if (state_q != ST_RUN) begin
			// the loop choice cannot move once locking has begun
			if (state_q != ST_LOCK)
				pll_enable_o           <= s_clk_mode;
			boot_port_wide_o           <= s_width;
			interrupt_port_pins_o      <= ~s_irqcfg;
			arb_pins_chip_select_o     <= s_arb;
			background_debug_mode_en_o <= ~s_break_n;
		end
	end

	assign clock_multiplier_o = pll_enable_o ? `PLL_MULTIPLIER : 10'd1;
	assign boot_addr_incr_o   = boot_port_wide_o ? `BOOT_INCR_WIDE : `BOOT_INCR_NARROW;

	boot_strobe_gen u_boot_strobe (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i || wdog_expired_q),
		.start_i     (strobe_start_q),
		.count_i     (boot_port_wide_o ? `BOOT_PULSES_WIDE : `BOOT_PULSES_NARROW),
		.boot_cs_n_o (boot_chip_select_n_o),
		.done_o      (boot_strobes_done_o)
	);

	// run-time pin effects
	reg fetch_seen_q;
	always @(posedge mclk_i) begin
		if (in_reset) begin
			fetch_seen_q                  <= 1'b0;
			level7_interrupt_o            <= 1'b0;
			bus_released_o                <= 1'b0;
			background_debug_mode_enter_o <= 1'b0;
			// follows the pin, so a pin held low through release is no entry
			brk_prev_q                    <= s_break_n;
		end else begin
			if (vector_fetch_done_i)
				fetch_seen_q <= 1'b1;
			// a level 7 request is held off until the vector fetch is done
			level7_interrupt_o <= !s_level7_n && !interrupt_port_pins_o
			                      && (fetch_seen_q || vector_fetch_done_i);
			bus_released_o <= !arb_pins_chip_select_o
			                  && (!s_busreq_n || !s_grant_ack_n);
			brk_prev_q <= s_break_n;
			if (background_debug_mode_en_o && brk_prev_q && !s_break_n)
				background_debug_mode_enter_o <= 1'b1;
		end
	end

	// watchdog and write-once protection control
	always @(posedge mclk_i) begin
		if (in_reset) begin
			watchdog_enable_o <= SYSPROT_INIT[`SYSPROT_WDE_BIT];
			sysprot_written_o <= 1'b0;
			wdog_cnt_q        <= 64'd0;
			wdog_key_armed_q  <= 1'b0;
		end else begin
			if (sysprot_wr_i && !sysprot_written_o) begin
				sysprot_written_o <= 1'b1; // later writes ignored
				watchdog_enable_o <= sysprot_wdata_i[`SYSPROT_WDE_BIT];
			end
			if (wdog_service_wr_i) begin
				if (wdog_service_data_i == `WDOG_KEY_FIRST)
					wdog_key_armed_q <= 1'b1;
				else if (wdog_service_data_i == `WDOG_KEY_SECOND && wdog_key_armed_q) begin
					wdog_key_armed_q <= 1'b0;
					wdog_cnt_q       <= 64'd0; // serviced in time
				end else
					wdog_key_armed_q <= 1'b0;
			end else if (watchdog_enable_o && wdog_cnt_q < WDOG_CYCLES - 64'd1)
				wdog_cnt_q <= wdog_cnt_q + 64'd1;
		end
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			wdog_expired_q  <= 1'b0;
			watchdog_reset_o <= 1'b0;
		end else begin
			// one-clock internal reset on timeout restarts the release sequence
			wdog_expired_q  <= !in_reset && watchdog_enable_o
			                   && wdog_cnt_q >= WDOG_CYCLES - 64'd1;
			watchdog_reset_o <= !in_reset && watchdog_enable_o
			                   && wdog_cnt_q >= WDOG_CYCLES - 64'd1;
		end
	end

endmodule

`default_nettype wire

// [test/reset_config_sampler_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module reset_config_sampler_checker (
	input wire logic       mclk_i,
	input wire logic       srst_i,
	input wire logic       reset_out_n_o,
	input wire logic       pll_enable_o,
	input wire logic [9:0] clock_multiplier_o,
	input wire logic       boot_port_wide_o,
	input wire logic [2:0] boot_addr_incr_o,
	input wire logic       boot_chip_select_n_o,
	input wire logic       interrupt_port_pins_o,
	input wire logic       level7_interrupt_o,
	input wire logic       watchdog_enable_o,
	input wire logic       sysprot_written_o,
	input wire logic       watchdog_reset_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// low time of the reset output, restarted by every new hold
	logic [9:0] low_q;
	always @(posedge mclk_i)
		low_q <= (srst_i || reset_out_n_o) ? 10'h000 : low_q + 10'h001;
	sequence strobe;
		!boot_chip_select_n_o ##1 boot_chip_select_n_o;
	endsequence
	chk_hold_min: assert property ($rose(reset_out_n_o) |-> low_q >= 10'h1FF)
		else $error("reset output released early");
	chk_strobe_run: assert property ($rose(reset_out_n_o) |-> ##[1:3] strobe ##1 strobe)
		else $error("boot strobes missing");
	chk_pll_mul: assert property (clock_multiplier_o=={pll_enable_o,8'h00,!pll_enable_o})
		else $error("clock multiplier wrong");
	chk_boot_incr:
		assert property (boot_addr_incr_o == {1'h0, boot_port_wide_o, !boot_port_wide_o})
		else $error("boot increment wrong");
	chk_straps_held:
		assert property (reset_out_n_o && $past(reset_out_n_o) |->
			$stable({pll_enable_o, boot_port_wide_o, interrupt_port_pins_o}))
		else $error("straps changed after release");
	chk_l7_gate: assert property (level7_interrupt_o |-> !interrupt_port_pins_o)
		else $error("level 7 seen on port pins");
	chk_once_only: assert property (sysprot_written_o |=> $stable(watchdog_enable_o))
		else $error("second protection write took effect");
	chk_wdog_reset: assert property (watchdog_reset_o |-> ##[1:2] !reset_out_n_o)
		else $error("timeout did not reset");
endmodule
`default_nettype wire

// [test/board_model.sv]
`timescale 1ns/10ps
`default_nettype none
module board_model (
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	input  wire logic       strobes_done_i,
	input  wire logic       svc_en_i,
	output logic            pll_locked_o,
	output logic            fetch_done_o,
	output logic            svc_wr_o,
	output logic [7:0]      svc_data_o
);
	logic [9:0] t_q, f_q;
	always @(posedge mclk_i) begin
		t_q <= srst_i ? 10'h000 : t_q + 10'h001;
		// lock lands after the minimum hold, so the release has to wait for it
		pll_locked_o <= !srst_i && (pll_locked_o || t_q == 10'h258);
		// a hung early cycle is ended by the host's bus error, so fetching always finishes
		f_q <= strobes_done_i ? f_q + {9'h000, f_q != 10'h01E} : 10'h000;
		// boot code has the stack chip-select up before it lets interrupts in
		fetch_done_o <= f_q == 10'h01E;
		svc_wr_o <= svc_en_i && t_q[5:1] == 5'h00;
		// idle data toggles so a stale key is never seen
		svc_data_o <= (svc_en_i && t_q[5:1] == 5'h00) ? (t_q[0] ? 8'hAA : 8'h55) : ~svc_data_o;
	end
endmodule
`default_nettype wire

// [test/reset_config_sampler_test.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module reset_config_sampler_test;
	wire lk, fd, swr, cs;
	wire [7:0] sd;
	wire [12:0] ob;
	logic mclk_i = 0, srst_i = 1, spw = 0, se = 1, pcs, ws;
	logic [7:0] swd = 8'h00;
	logic [4:0] st = 5'h1F, lt;
	logic [2:0] pn = 3'h7;
	logic [3:0] pc;
	logic [15:0] q[$], ev;
	int err_total = 0, cmp_count = 0, seed = 32'h3dc5, i, k, r;
	always #2.5 mclk_i = ~mclk_i;
	reset_config_sampler #(.WDOG_CYCLES(64'h12C)) dut (.mclk_i(mclk_i), .srst_i(srst_i),
		.pll_locked_i(lk), .clock_mode_select_pin_i(st[4]), .boot_width_config_bit_i(st[3]),
		.arbitration_pin_config_bit_i(st[2]), .interrupt_pin_config_bit_i(st[1]),
		.breakpoint_request_pin_n_i(st[0]), .bus_request_pin_n_i(pn[2]),
		.bus_grant_ack_pin_n_i(pn[1]), .level7_interrupt_request_n_i(pn[0]),
		.vector_fetch_done_i(fd), .sysprot_wr_i(spw), .sysprot_wdata_i(swd),
		.wdog_service_wr_i(swr), .wdog_service_data_i(sd), .reset_out_n_o(ob[11]),
		.pll_enable_o(ob[10]), .clock_multiplier_o(), .boot_port_wide_o(ob[9]),
		.boot_addr_incr_o(), .boot_chip_select_n_o(cs), .boot_strobes_done_o(ob[12]),
		.interrupt_port_pins_o(ob[8]), .arb_pins_chip_select_o(ob[7]),
		.background_debug_mode_en_o(ob[6]), .background_debug_mode_enter_o(ob[5]),
		.level7_interrupt_o(ob[4]), .bus_released_o(ob[3]), .watchdog_enable_o(ob[2]),
		.sysprot_written_o(ob[1]), .watchdog_reset_o(ob[0]));
	board_model bm (.mclk_i(mclk_i), .srst_i(srst_i), .strobes_done_i(ob[12]), .svc_en_i(se),
		.pll_locked_o(lk), .fetch_done_o(fd), .svc_wr_o(swr), .svc_data_o(sd));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wait_bit(input int b);
		for (k = 0; k < 5000 && ob[b] !== 1'b1; k++)
			step(1);
		err_total += int'(k == 5000);
		if (k == 5000)
			print_verdict();
	endtask
	function automatic logic [15:0] ex(input logic l7, dn, we, wt, w);
		return {lt[3] ? 4'h5 : 4'h9, 1'h1, lt[4], lt[3], !lt[1], lt[2], !lt[0], dn, l7,
			pn[2:1] != 2'h3 && !lt[2], we, wt, w};
	endfunction
	// strobe count and timeout flag gathered beside the live outputs
	always @(posedge mclk_i) begin
		pc <= ob[11] ? pc + {3'h0, pcs & !cs} : 4'h0;
		pcs <= cs;
		ws <= !srst_i && (ws || ob[0]);
		if (q.size() > 0) begin
			ev = q.pop_front();
			`CHK("outputs", ev, {pc, ob[11:1], ws})
		end
	end
	initial begin
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			st = {i[0], i[1], r[2:0]};
			{pn, se} = 4'hF;
			srst_i = 1;
			step(6);
			srst_i = 0;
			wait_bit(11);
			lt = st;
			// pins move right after release and must not disturb the settings
			{st, pn[0]} = {~st | 5'h01, 1'h0};
			wait_bit(12);
			step(2);
			q.push_back(ex(0, 0, 1, 0, 0));
			step(40);
			{pn[1 + i[0]], st[0]} = 2'h0;
			step(6);
			{spw, swd} = {1'h1, i[0] ? 8'h00 : 8'h80};
			step(1);
			swd = i[0] ? 8'h80 : 8'h00;
			step(1);
			spw = 0;
			q.push_back(ex(lt[1], !lt[0], !i[0], 1, 0));
			if (!i[0]) begin
				step(400);
				q.push_back(ex(lt[1], !lt[0], 1, 1, 0));
				se = 0;
				wait_bit(0);
				step(3);
				wait_bit(11);
				lt = st;
				wait_bit(12);
				step(2);
				q.push_back(ex(0, 0, 1, 0, 1));
			end
		end
		step(3);
		print_verdict();
	end
endmodule
bind reset_config_sampler reset_config_sampler_checker chk (.mclk_i(mclk_i), .srst_i(srst_i),
	.reset_out_n_o(reset_out_n_o), .pll_enable_o(pll_enable_o),
	.clock_multiplier_o(clock_multiplier_o), .boot_port_wide_o(boot_port_wide_o),
	.boot_addr_incr_o(boot_addr_incr_o), .boot_chip_select_n_o(boot_chip_select_n_o),
	.interrupt_port_pins_o(interrupt_port_pins_o), .level7_interrupt_o(level7_interrupt_o),
	.watchdog_enable_o(watchdog_enable_o), .sysprot_written_o(sysprot_written_o),
	.watchdog_reset_o(watchdog_reset_o));
`default_nettype wire
